// file: tb/ptp_rx_sva.sv
// Concurrent checks on the bus, result and interrupt ports of the receive block
`timescale 1ns/10ps
module ptp_rx_sva
  import ptp_rx_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [12:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  logic rd_ok;
  logic res_rd;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign res_rd = rd_ok && avs_address == REG_RESULT;

  a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("answer held too long");
  a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_no_stray_ack: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_rdata_holds: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved");
  a_result_excl: assert property (res_rd |-> !(avs_readdata[EV_NDR] && avs_readdata[EV_ERR]))
    else $error("new data and error together");
  a_err_code: assert property (res_rd && avs_readdata[EV_ERR] |-> avs_readdata[31])
    else $error("error with normal code");
  a_ndr_code: assert property (res_rd && avs_readdata[EV_NDR] |-> !avs_readdata[31])
    else $error("new data with error code");
  a_len_bound: assert property (rd_ok && avs_address == REG_LENGTH |-> avs_readdata <= 32'h400)
    else $error("length beyond store");
  a_queue_bound: assert property (rd_ok && avs_address == REG_QUEUE
    |-> avs_readdata[3:0] <= DESC_FULL && avs_readdata[19:9] <= STORE_FULL) else $error("queue overfull");
  a_mask_quiets: assert property (avs_write && !avs_waitrequest && avs_address == REG_IRQ_MASK
    && avs_byteenable[0] && avs_writedata[2:0] == 3'h0 |-> ##2 !irq) else $error("irq with all masked");
  c_ndr: cover property (res_rd && avs_readdata[EV_NDR]);
  c_err: cover property (res_rd && avs_readdata[EV_ERR]);
  c_irq: cover property ($rose(irq));
endmodule

bind ptp_receive_and_signal_status ptp_rx_sva ptp_rx_sva_i (.core_clk, .reset_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);

// file: tb/serial_rx_model.sv
// Stand-in for the serial receiver and modem lines ahead of the receive block
`timescale 1ns/10ps
module serial_rx_model (
  input wire logic core_clk,
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_last = 1'b0,
  output logic [15:0] rx_code = 16'h0000,
  output logic [5:0] lines = 6'h00
);
  // Idle data and code flip, so a stale value never passes for a fresh one
  task automatic send(input int len, input logic [15:0] code, input int gap, input logic [7:0] base);
    for (int i = 0; i < len; i++) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= base + 8'(i * 3);
      rx_last <= (i == len - 1);
      rx_code <= (i == len - 1) ? code : ~rx_code;
      repeat (gap) begin
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
    rx_code <= ~rx_code;
  endtask
endmodule

// file: tb/test_ptp_receive_and_signal_status.sv
// Self-checking bench for the point-to-point receive block
`timescale 1ns/10ps
module test_ptp_receive_and_signal_status;
  import ptp_rx_pkg::*;
  logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq, rx_valid, rx_last, variant_rs485;
  logic [12:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [3:0] avs_byteenable;
  logic [7:0] rx_data;
  logic [15:0] rx_code;
  logic [5:0] lines;
  int n_errors, n_compared, cyc;
  logic [15:0] codes [9] = '{ST_MAX_CHARS, ST_MSG_TIMEOUT, ST_GAP_TIMEOUT, ST_RESP_TIMEOUT, ST_HLT_RULE,
    ST_END_SEQ, ST_PARITY, ST_FRAMING, ST_OVERRUN};

  ptp_receive_and_signal_status ptp_receive_and_signal_status_i (.core_clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .rx_valid, .rx_data,
    .rx_last, .rx_code, .variant_rs485, .line_dtr(lines[0]), .line_dsr(lines[1]), .line_rts(lines[2]),
    .line_cts(lines[3]), .line_dcd(lines[4]), .line_ri(lines[5]));
  serial_rx_model serial_rx_model_i (.core_clk, .rx_valid, .rx_data, .rx_last, .rx_code, .lines);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request stays put until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rv);
  endtask

  task automatic rchk(input logic [12:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, rv);
    chk(what, exp, rv);
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(posedge core_clk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  // Polls for an outcome; a measured pulse must last one scan, give or take one poll
  task automatic wait_res(input logic [2:0] ev, input logic [15:0] st, input logic [31:0] len, input bit meas);
    int t0;
    do bus(1'b0, REG_RESULT, 32'h0, rv); while (rv[2:0] === 3'h0);
    t0 = cyc;
    chk("result", {st, 13'h0, ev}, {rv[31:16], 13'h0, rv[2:0]});
    if (len !== '1) begin
      rchk(REG_LENGTH, len, "length");
    end
    if (meas) begin
      do bus(1'b0, REG_RESULT, 32'h0, rv); while (rv[2:0] !== 3'h0 && cyc - t0 < 300);
      chk("pulse_cycles", 32'h1, 32'(cyc - t0 > 93 && cyc - t0 < 104));
    end else begin
      repeat (100) @(posedge core_clk);
    end
  endtask

  initial begin
    reset_n = 1'b0;
    avs_address = 13'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    variant_rs485 = 1'b0;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rchk(REG_HOST_SIZE, 32'h400, "host_size");
    rchk(REG_QUEUE, 32'h0, "queue_empty");
    avs_byteenable <= 4'h1;
    wr(REG_HOST_SIZE, 32'h10);
    rchk(REG_HOST_SIZE, 32'h400, "host_size_lane");
    avs_byteenable <= 4'hf;
    wr(REG_HOST_SIZE, 32'h7ff);
    rchk(REG_HOST_SIZE, 32'h400, "host_size_clamp");
    wr(13'h0020, 32'hffffffff);
    rchk(13'h0020, 32'h0, "unmapped");
    wr(REG_IRQ_MASK, 32'h7);
    // Two messages wait while polling is off; the first overruns a small host buffer
    serial_rx_model_i.send(5, ST_HLT_RULE, 0, 8'h10);
    serial_rx_model_i.send(3, ST_FRAMING, 2, 8'h10);
    rchk(REG_QUEUE, 32'h0000_1002, "queue_two");
    wr(REG_HOST_SIZE, 32'h4);
    wr(REG_CTRL, 32'h1);
    wait_res(3'h2, ST_LEN_OVER, 32'h4, 0);
    wait_res(3'h2, ST_FRAMING, 32'h3, 0);
    wr(REG_HOST_SIZE, 32'h400);
    foreach (codes[k]) begin
      serial_rx_model_i.send(2, codes[k], k, 8'(k * 16));
      wait_res(codes[k][15] ? 3'h2 : 3'h1, codes[k], 32'h2, 1);
      rchk(13'h1004, {24'h0, 8'(k * 16 + 3)}, "host_byte");
    end
    irq_is(1'b1);
    rchk(REG_IRQ_STATUS, 32'h3, "irq_status");
    wr(REG_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    wr(REG_IRQ_MASK, 32'h7);
    irq_is(1'b1);
    wr(REG_IRQ_STATUS, 32'h3);
    irq_is(1'b0);
    rchk(REG_IRQ_STATUS, 32'h0, "irq_cleared");
    // Overlong message fills the store; a reset during its delivery is refused
    wr(REG_CTRL, 32'h0);
    serial_rx_model_i.send(1030, ST_END_SEQ, 0, 8'h00);
    rchk(REG_QUEUE, 32'h0008_0001, "queue_full");
    wr(REG_CTRL, 32'h1);
    repeat (150) @(posedge core_clk);
    wr(REG_CTRL, 32'h3);
    wait_res(3'h2, ST_RST_BUSY, '1, 0);
    wait_res(3'h2, ST_STORE_FULL, 32'h400, 0);
    wr(REG_CTRL, 32'h0);
    serial_rx_model_i.send(4, ST_END_SEQ, 1, 8'h40);
    rchk(REG_QUEUE, 32'h0000_0801, "queue_one");
    repeat (100) @(posedge core_clk);
    wr(REG_CTRL, 32'h2);
    wait_res(3'h4, ST_NONE, '1, 1);
    rchk(REG_QUEUE, 32'h0, "queue_cleared");
    serial_rx_model_i.lines <= 6'h2d;
    wr(REG_CTRL, 32'h4);
    wait_res(3'h1, ST_NONE, '1, 1);
    rchk(REG_LINES, 32'h2d, "lines");
    // Second reset in mid-run with the two-wire strap
    @(posedge core_clk);
    reset_n <= 1'b0;
    variant_rs485 <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    wr(REG_CTRL, 32'h4);
    wait_res(3'h2, ST_NO_SIGNALS, '1, 1);
    wrap_up();
  end
endmodule

// file: verilog/ptp_receive_and_signal_status.sv
// Receive store, message delivery, receiver reset and modem line read with Avalon-MM registers
// Overview of operation
// [RQ1] While receive enable is high, a queued complete message is copied to the host buffer.
// [RQ2] Host trusts the status word only in the scan where new-data or error shows.
// [RQ3] Status codes with bit 15 set mean error termination, clear means normal end.
// [RQ4] One shared 1K-byte store holds several received messages at once.
// [RQ5] An error-free delivery raises new-data-ready for exactly one scan.
// [RQ6] A failed receive or line read raises error one scan, status carries the cause.
// [RQ7] Each delivered message reports its returned byte count as an unsigned length.
// [RQ8] Parity, framing and overrun cut-offs report their matching error codes.
// [RQ9] Store-full stop and length beyond host buffer each have their own error code.
// [RQ10] Max count, header-length-trailer rule and end sequence each have a normal code.
// [RQ11] Message, inter-character and response timeouts each have their own code.
// [RQ12] A rising receiver-reset request discards everything in the receive store.
// [RQ13] Receiver reset pulses done one scan, or raises error with a code.
// [RQ14] A rising line-read request captures six modem lines and pulses new-data-ready.
// [RQ15] On the two-wire variant a line read fails with the no-signals code.
// [RQ16] Flow-control lock, DSR on terminal, DTR on data-set have distinct codes.
// [RQ17] Error codes carry bit 15 set, class in bits 7:4, number in 3:0.
// [RQ18] Messages queue whole, leave oldest first, one per poll, space reclaimed after.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module ptp_receive_and_signal_status
  import ptp_rx_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [12:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic [15:0] rx_code,
  input wire logic variant_rs485,
  input wire logic line_dtr,
  input wire logic line_dsr,
  input wire logic line_rts,
  input wire logic line_cts,
  input wire logic line_dcd,
  input wire logic line_ri
);

  typedef struct packed {
    logic rx_en;
    logic rst_req;
    logic sig_req;
    logic rst_seen;
    logic sig_seen;
    logic [10:0] host_size;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic irq;
    logic ack;
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] scan_cnt;
    logic [2:0] events;
    logic [15:0] status;
    logic [10:0] length;
    logic [5:0] lines;
    logic [2:0] pend;
    logic [15:0] pend_status;
    logic [10:0] pend_length;
    dlv_state_t dlv;
    logic [10:0] copy_idx;
    logic [10:0] copy_len;
    logic [10:0] msg_len;
    logic [15:0] msg_code;
    logic [STORE_AW-1:0] rptr;
    logic [STORE_AW-1:0] wptr;
    logic [10:0] used;
    logic [10:0] cur_len;
    logic dropping;
    logic [DESC_AW-1:0] dhead;
    logic [DESC_AW-1:0] dtail;
    logic [3:0] dcount;
    logic is_rs485;
    logic strap_taken;
  } state_t;

  state_t s;
  state_t next_s;
  logic [1:0] rst_sync;
  logic rst_n;

  logic [7:0] store_mem [STORE_BYTES];
  logic [7:0] host_mem [STORE_BYTES];
  logic [10:0] desc_len [DESC_DEPTH];
  logic [15:0] desc_code [DESC_DEPTH];

  logic store_we;
  logic host_we;
  logic desc_we;
  logic [10:0] desc_wlen;
  logic [15:0] desc_wcode;

  function automatic logic code_is_error(input logic [15:0] code);
    return code[15]; // [RQ3]
  endfunction

  function automatic logic reg_hit(input logic [12:0] addr, input logic [12:0] offset);
    return addr == offset;
  endfunction

  // One-hot event word from a package bit position
  function automatic logic [2:0] event_bit(input int pos);
    return 3'(1 << pos);
  endfunction

  // Oversize beats a normal code, never an error code
  function automatic logic [15:0] verdict_code(input logic [10:0] len, input logic [15:0] code,
    input logic [10:0] size);
    if (len > size && !code_is_error(code)) begin
      return ST_LEN_OVER; // [RQ9]
    end
    return code; // [RQ8] [RQ10] [RQ11]
  endfunction

  function automatic logic [2:0] verdict_events(input logic [10:0] len, input logic [15:0] code,
    input logic [10:0] size);
    if (code_is_error(code) || len > size) begin
      return event_bit(EV_ERR); // [RQ6]
    end
    return event_bit(EV_NDR); // [RQ5]
  endfunction

  // Signal-handling failures; only the first is ever requested by this block
  function automatic logic [15:0] signal_code(input logic [1:0] cause);
    case (cause)
      2'h0: return ST_NO_SIGNALS; // [RQ15]
      2'h1: return ST_FLOW_LOCK; // [RQ16]
      2'h2: return ST_DSR_ON_DTE; // [RQ16]
      2'h3: return ST_DTR_ON_DCE; // [RQ16]
      default: return ST_NO_SIGNALS;
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_comb begin
    logic tick;
    logic wr_now;
    logic rd_now;
    logic [31:0] rd_val;
    logic close_msg;
    logic [10:0] close_len;
    logic [15:0] close_code;
    logic [2:0] new_events;
    logic queue_room;
    tick = 1'b0;
    wr_now = 1'b0;
    rd_now = 1'b0;
    rd_val = 32'h0000_0000;
    close_msg = 1'b0;
    close_len = 11'h000;
    close_code = ST_NONE;
    new_events = 3'b000;
    queue_room = 1'b0;
    next_s = s;
    store_we = 1'b0;
    host_we = 1'b0;
    desc_we = 1'b0;
    desc_wlen = 11'h000;
    desc_wcode = ST_NONE;

    // Variant strap caught once after reset release
    if (!s.strap_taken) begin
      next_s.is_rs485 = variant_rs485;
      next_s.strap_taken = 1'b1;
    end

    // Scan divider
    tick = (s.scan_cnt == SCAN_LAST);
    next_s.scan_cnt = tick ? 8'h00 : s.scan_cnt + 8'h01;

    // Delivery of the oldest queued message
    if (s.dlv == DLV_COPY) begin
      if (s.copy_idx != s.copy_len) begin
        host_we = 1'b1; // [RQ1]
        next_s.rptr = s.rptr + 10'h001;
        next_s.copy_idx = s.copy_idx + 11'h001;
      end else begin
        // Skipped tail of an oversize message is reclaimed too
        next_s.rptr = s.rptr + s.msg_len[STORE_AW-1:0] - s.copy_len[STORE_AW-1:0]; // [RQ18]
        next_s.used = s.used - s.msg_len; // [RQ18]
        next_s.dhead = s.dhead + 3'h1;
        next_s.dcount = s.dcount - 4'h1;
        next_s.pend_length = s.copy_len; // [RQ7]
        next_s.pend_status = verdict_code(s.msg_len, s.msg_code, s.host_size); // [RQ8] [RQ9]
        next_s.pend = verdict_events(s.msg_len, s.msg_code, s.host_size); // [RQ5] [RQ6]
        next_s.dlv = DLV_IDLE;
      end
    end

    // Incoming bytes into the shared store
    if (rx_valid) begin
      if (s.dropping) begin
        next_s.dropping = !rx_last;
      end else if (s.used == STORE_FULL) begin
        close_msg = 1'b1; // [RQ9]
        close_len = s.cur_len;
        close_code = ST_STORE_FULL;
        next_s.dropping = !rx_last;
      end else begin
        store_we = 1'b1; // [RQ4]
        next_s.wptr = s.wptr + 10'h001;
        next_s.used = next_s.used + 11'h001;
        close_msg = rx_last;
        close_len = s.cur_len + 11'h001;
        close_code = rx_code; // [RQ8] [RQ10] [RQ11]
        next_s.cur_len = s.cur_len + 11'h001;
      end
    end
    if (close_msg) begin
      next_s.cur_len = 11'h000;
      // A slot freed by a finishing delivery can take the closing message
      queue_room = (s.dcount != DESC_FULL) || (s.dlv == DLV_COPY && s.copy_idx == s.copy_len);
      if (!queue_room) begin
        // Queue full: message discarded whole, its bytes given back
        next_s.wptr = next_s.wptr - close_len[STORE_AW-1:0];
        next_s.used = next_s.used - close_len;
      end else begin
        desc_we = 1'b1; // [RQ18]
        desc_wlen = close_len;
        desc_wcode = close_code;
        next_s.dtail = s.dtail + 3'h1;
        next_s.dcount = next_s.dcount + 4'h1;
      end
    end

    // Scan boundary: show pending result for one scan, sample requests
    if (tick) begin
      new_events = s.pend;
      next_s.events = s.pend; // [RQ5] [RQ6] [RQ13]
      next_s.pend = 3'b000;
      if (s.pend != 3'b000) begin
        next_s.status = s.pend_status; // [RQ6]
        next_s.length = s.pend_length;
      end
      next_s.rst_seen = s.rst_req;
      next_s.sig_seen = s.sig_req;
      if (s.rst_req && !s.rst_seen) begin
        if (s.dlv == DLV_COPY) begin
          next_s.pend = event_bit(EV_ERR); // [RQ13]
          next_s.pend_status = ST_RST_BUSY; // [RQ17]
        end else begin
          next_s.rptr = 10'h000; // [RQ12]
          next_s.wptr = 10'h000;
          next_s.used = 11'h000;
          next_s.dhead = 3'h0;
          next_s.dtail = 3'h0;
          next_s.dcount = 4'h0;
          next_s.cur_len = 11'h000;
          // A message still arriving is thrown away up to its end
          next_s.dropping = (s.cur_len != 11'h000 && !(rx_valid && rx_last)) || next_s.dropping;
          next_s.pend = event_bit(EV_DONE); // [RQ13]
          next_s.pend_status = ST_NONE;
        end
      end else if (s.sig_req && !s.sig_seen) begin
        if (s.is_rs485) begin
          next_s.pend = event_bit(EV_ERR); // [RQ15]
          next_s.pend_status = signal_code(2'h0);
        end else begin
          next_s.lines = {line_ri, line_dcd, line_cts, line_rts, line_dsr, line_dtr}; // [RQ14]
          next_s.pend = event_bit(EV_NDR); // [RQ14]
          next_s.pend_status = ST_NONE;
        end
      end else if (s.rx_en && s.dlv == DLV_IDLE && s.dcount != 4'h0) begin
        next_s.dlv = DLV_COPY; // [RQ1] [RQ18]
        next_s.copy_idx = 11'h000;
        next_s.msg_len = desc_len[s.dhead];
        next_s.msg_code = desc_code[s.dhead];
        next_s.copy_len = (desc_len[s.dhead] > s.host_size) ? s.host_size : desc_len[s.dhead];
      end
    end else begin
      next_s.events = s.events;
    end

    // Avalon-MM slave: answer one cycle after the request
    rd_now = avs_read && !s.ack;
    wr_now = avs_write && s.ack;
    next_s.ack = (avs_read || avs_write) && !s.ack;
    next_s.waitreq = !next_s.ack;
    if (avs_address[HOST_WIN_BIT]) begin
      rd_val = {24'h000000, host_mem[avs_address[11:2]]};
    end else if (reg_hit(avs_address, REG_CTRL)) begin
      rd_val = {29'h0, s.sig_req, s.rst_req, s.rx_en};
    end else if (reg_hit(avs_address, REG_RESULT)) begin
      rd_val = {s.status, 12'h000, (s.dlv == DLV_COPY), s.events}; // [RQ2]
    end else if (reg_hit(avs_address, REG_LENGTH)) begin
      rd_val = {21'h0, s.length};
    end else if (reg_hit(avs_address, REG_LINES)) begin
      rd_val = {26'h0, s.lines};
    end else if (reg_hit(avs_address, REG_HOST_SIZE)) begin
      rd_val = {21'h0, s.host_size};
    end else if (reg_hit(avs_address, REG_IRQ_STATUS)) begin
      rd_val = {29'h0, s.irq_status};
    end else if (reg_hit(avs_address, REG_IRQ_MASK)) begin
      rd_val = {29'h0, s.irq_mask};
    end else if (reg_hit(avs_address, REG_QUEUE)) begin
      rd_val = {12'h000, s.used, 5'h00, s.dcount};
    end
    if (rd_now) begin
      next_s.rdata = rd_val;
    end

    // Write-one-to-clear; a new event in the same cycle wins
    next_s.irq_status = s.irq_status;
    if (wr_now && avs_byteenable[0]) begin
      if (reg_hit(avs_address, REG_CTRL)) begin
        next_s.rx_en = avs_writedata[CTRL_RX_EN];
        next_s.rst_req = avs_writedata[CTRL_RST_REQ];
        next_s.sig_req = avs_writedata[CTRL_SIG_REQ];
      end
      if (reg_hit(avs_address, REG_IRQ_STATUS)) begin
        next_s.irq_status = s.irq_status & ~avs_writedata[2:0];
      end
      if (reg_hit(avs_address, REG_IRQ_MASK)) begin
        next_s.irq_mask = avs_writedata[2:0];
      end
    end
    if (wr_now && avs_byteenable[1:0] == 2'b11 && reg_hit(avs_address, REG_HOST_SIZE)) begin
      next_s.host_size = (avs_writedata[15:0] > 16'(STORE_BYTES)) ? HOST_SIZE_RESET : avs_writedata[10:0];
    end
    next_s.irq_status = next_s.irq_status | new_events;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.host_size <= HOST_SIZE_RESET;
      s.waitreq <= 1'b1;
      s.dlv <= DLV_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Memories carry no reset; pointers decide what is valid
  always_ff @(posedge core_clk) begin
    if (store_we) begin
      store_mem[s.wptr] <= rx_data;
    end
    if (host_we) begin
      host_mem[s.copy_idx[STORE_AW-1:0]] <= store_mem[s.rptr];
    end
    if (desc_we) begin
      desc_len[s.dtail] <= desc_wlen;
      desc_code[s.dtail] <= desc_wcode;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign irq = s.irq;

endmodule

// file: verilog/ptp_rx_pkg.sv
// Constants, codes and register map of the point-to-point receive block
package ptp_rx_pkg;
  // Receive store and message queue
  localparam int STORE_BYTES = 1024;
  localparam int STORE_AW = 10;
  localparam int DESC_DEPTH = 8;
  localparam int DESC_AW = 3;
  localparam logic [10:0] STORE_FULL = 11'h400;
  localparam logic [3:0] DESC_FULL = 4'h8;
  localparam logic [10:0] HOST_SIZE_RESET = 11'h400;

  // Scan period derived from time and clock rate
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCAN_TIME_NS = 10000;
  localparam int SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SCAN_LAST = 8'(SCAN_CYCLES - 1);

  // Register byte offsets
  localparam logic [12:0] REG_CTRL = 13'h0000;
  localparam logic [12:0] REG_RESULT = 13'h0004;
  localparam logic [12:0] REG_LENGTH = 13'h0008;
  localparam logic [12:0] REG_LINES = 13'h000c;
  localparam logic [12:0] REG_HOST_SIZE = 13'h0010;
  localparam logic [12:0] REG_IRQ_STATUS = 13'h0014;
  localparam logic [12:0] REG_IRQ_MASK = 13'h0018;
  localparam logic [12:0] REG_QUEUE = 13'h001c;
  localparam int HOST_WIN_BIT = 12;

  // Control bit positions
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_RST_REQ = 1;
  localparam int CTRL_SIG_REQ = 2;
  // Event bit positions (result and interrupt layout)
  localparam int EV_NDR = 0;
  localparam int EV_ERR = 1;
  localparam int EV_DONE = 2;
  localparam int RES_BUSY = 3;
  localparam int RES_STATUS_LSB = 16;

  // Termination and status codes: bit 15 error, class 7:4, number 3:0
  localparam logic [15:0] ST_NONE = 16'h0000;
  localparam logic [15:0] ST_STORE_FULL = 16'h80e0;
  localparam logic [15:0] ST_PARITY = 16'h80e1;
  localparam logic [15:0] ST_FRAMING = 16'h80e2;
  localparam logic [15:0] ST_OVERRUN = 16'h80e3;
  localparam logic [15:0] ST_LEN_OVER = 16'h80e4;
  localparam logic [15:0] ST_RST_BUSY = 16'h80e5;
  localparam logic [15:0] ST_MAX_CHARS = 16'h0094;
  localparam logic [15:0] ST_MSG_TIMEOUT = 16'h0095;
  localparam logic [15:0] ST_GAP_TIMEOUT = 16'h0096;
  localparam logic [15:0] ST_RESP_TIMEOUT = 16'h0097;
  localparam logic [15:0] ST_HLT_RULE = 16'h0098;
  localparam logic [15:0] ST_END_SEQ = 16'h0099;
  localparam logic [15:0] ST_NO_SIGNALS = 16'h80f0;
  localparam logic [15:0] ST_FLOW_LOCK = 16'h80f1;
  localparam logic [15:0] ST_DSR_ON_DTE = 16'h80f2;
  localparam logic [15:0] ST_DTR_ON_DCE = 16'h80f3;

  typedef enum logic [0:0] {
    DLV_IDLE = 1'b0,
    DLV_COPY = 1'b1
  } dlv_state_t;
endpackage
